// *** common/crc_pkg.sv ***
// Notes on behaviour
// - while restart low, reset, pull status and complete low, float all I/O.
// - configuration begins after restart high and status released.
// - on error, pull status low and keep complete low.
// - with auto restart, release status within 230 us then retry.
// - init clock is internal oscillator, or user start-up clock when enabled.
// - without user clock enable, internal oscillator supplies every init cycle; user clock pin is free.
// - after data accepted and complete high, run 3192 init cycles.
// - user clock withheld stalls user-mode entry; it never disturbs configuration.
// - init-complete driven low once first-frame enable bit is loaded.
// - init-complete released at end of init, marking user mode.
// - in user mode user I/O follow the design, pull-ups removed.
// - byte-wide chain: low data byte feeds every slave.
// - word-wide chain: chain enable starts two chains, low and high byte.
// - on own data done, assert chain enable and release complete line.
// - shared complete line rises when all release; init starts together.
// - flash wait ignored during active parallel configuration.
// - chain enable output driven low once own configuration completes.
package crc_pkg;
   // =========================================
   // timing
   localparam int unsigned CLK_MHZ = 50;
   localparam int unsigned RETRY_TIMEOUT_US = 230;
   localparam int unsigned RETRY_CYCLES = RETRY_TIMEOUT_US * CLK_MHZ;
   localparam logic [11:0] INIT_CYCLES = 12'hC78;
   localparam logic [13:0] RETRY_CYCLES_W = 14'(RETRY_CYCLES);

   // =========================================
   // states
   typedef enum logic [5:0] {
      ST_RESET = 6'h01,
      ST_CONFIG = 6'h02,
      ST_WAIT_DONE = 6'h04,
      ST_INIT = 6'h08,
      ST_USER = 6'h10,
      ST_ERROR = 6'h20
   } crc_state_e;

   // open-drain pin pair
   typedef struct packed {
      logic out;
      logic oe;
   } crc_od_s;
endpackage

// *** logic/crc_config_restart_init_chain.sv ***
`timescale 1ns/1ns
module crc_config_restart_init_chain #(
   parameter int unsigned RETRY_COUNT = crc_pkg::RETRY_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // options
   input wire logic auto_restart_en,
   input wire logic user_clock_en,
   input wire logic word_wide_mode,
   // configuration pins
   input wire logic config_restart_n,
   input wire logic chip_enable_in_n,
   input wire logic config_status_n_in,
   output logic config_status_n_out,
   output logic config_status_n_oe,
   input wire logic config_complete_in,
   output logic config_complete_out,
   output logic config_complete_oe,
   output logic chain_enable_out_n,
   output logic init_complete_out,
   output logic init_complete_oe,
   input wire logic user_startup_clock,
   input wire logic flash_wait,
   // configuration data stream
   input wire logic [15:0] cfg_data,
   input wire logic cfg_data_valid,
   input wire logic cfg_data_last,
   input wire logic cfg_error,
   // chain data out
   output logic [7:0] chain_low_data,
   output logic [7:0] chain_high_data,
   output logic chain_data_valid,
   // user mode
   output logic user_mode,
   output logic io_tristate,
   output logic io_weak_pullup
);
   crc_pkg::crc_state_e state_reg;
   logic [13:0] retry_cnt_reg;
   logic [11:0] init_cnt_reg;
   logic init_en_reg;
   logic first_frame_reg;
   logic usr_d1_reg;
   logic usr_d2_reg;
   logic init_tick;
   logic usr_edge;
   logic flash_wait_unused;

   // =========================================
   // init clock source
   // user clock sampled as an ordinary input; second stage only feeds edge detect
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         usr_d1_reg <= 1'b0;
         usr_d2_reg <= 1'b0;
      end else begin
         usr_d1_reg <= user_startup_clock;
         usr_d2_reg <= usr_d1_reg;
      end
   end
   assign usr_edge = usr_d1_reg & ~usr_d2_reg;
   assign init_tick = user_clock_en ? usr_edge : 1'b1;
   // wait line is not looked at during configuration
   assign flash_wait_unused = flash_wait;

   // =========================================
   // sequencer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= crc_pkg::ST_RESET;
      end else if (!config_restart_n) begin
         state_reg <= crc_pkg::ST_RESET;
      end else begin
         case (state_reg)
            crc_pkg::ST_RESET: begin
               // status released by us in this state; wait for the wire to rise
               if (config_status_n_in && !chip_enable_in_n) begin
                  state_reg <= crc_pkg::ST_CONFIG;
               end
            end
            crc_pkg::ST_CONFIG: begin
               if (cfg_error) begin
                  state_reg <= crc_pkg::ST_ERROR;
               end else if (cfg_data_valid && cfg_data_last) begin
                  state_reg <= crc_pkg::ST_WAIT_DONE;
               end
            end
            crc_pkg::ST_WAIT_DONE: begin
               if (!config_status_n_in) begin
                  state_reg <= crc_pkg::ST_ERROR;
               end else if (config_complete_in) begin
                  state_reg <= crc_pkg::ST_INIT;
               end
            end
            crc_pkg::ST_INIT: begin
               if (init_tick && config_complete_in
                  && init_cnt_reg == crc_pkg::INIT_CYCLES - 12'h001) begin
                  state_reg <= crc_pkg::ST_USER;
               end
            end
            crc_pkg::ST_USER: begin
               state_reg <= crc_pkg::ST_USER;
            end
            crc_pkg::ST_ERROR: begin
               if (auto_restart_en && retry_cnt_reg == 14'(RETRY_COUNT - 1)) begin
                  state_reg <= crc_pkg::ST_RESET;
               end
            end
            default: begin
               state_reg <= crc_pkg::ST_RESET;
            end
         endcase
      end
   end

   // =========================================
   // retry timeout
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         retry_cnt_reg <= 14'h0000;
      end else if (state_reg == crc_pkg::ST_ERROR && auto_restart_en) begin
         retry_cnt_reg <= retry_cnt_reg + 14'h0001;
      end else begin
         retry_cnt_reg <= 14'h0000;
      end
   end

   // =========================================
   // init counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         init_cnt_reg <= 12'h000;
      end else if (!config_restart_n || state_reg != crc_pkg::ST_INIT) begin
         init_cnt_reg <= 12'h000;
      end else if (init_tick && config_complete_in) begin
         init_cnt_reg <= init_cnt_reg + 12'h001;
      end
   end

   // =========================================
   // init-complete enable from first frame (bit 0)
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         init_en_reg <= 1'b0;
         first_frame_reg <= 1'b1;
      end else if (state_reg == crc_pkg::ST_RESET) begin
         init_en_reg <= 1'b0;
         first_frame_reg <= 1'b1;
      end else if (state_reg == crc_pkg::ST_CONFIG && cfg_data_valid && first_frame_reg) begin
         init_en_reg <= cfg_data[0];
         first_frame_reg <= 1'b0;
      end
   end

   // =========================================
   // chain data forwarding
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chain_low_data <= 8'h00;
         chain_high_data <= 8'h00;
         chain_data_valid <= 1'b0;
      end else begin
         chain_low_data <= cfg_data[7:0];
         chain_high_data <= word_wide_mode ? cfg_data[15:8] : 8'h00;
         chain_data_valid <= cfg_data_valid && state_reg == crc_pkg::ST_CONFIG
            && chip_enable_in_n == 1'b0;
      end
   end

   // =========================================
   // pins
   always_comb begin
      config_status_n_out = 1'b0;
      config_status_n_oe = (state_reg == crc_pkg::ST_ERROR) || !config_restart_n;
      config_complete_out = 1'b0;
      config_complete_oe = (state_reg == crc_pkg::ST_RESET) ||
         (state_reg == crc_pkg::ST_CONFIG) || (state_reg == crc_pkg::ST_ERROR) ||
         !config_restart_n;
      init_complete_out = 1'b0;
      init_complete_oe = init_en_reg && state_reg != crc_pkg::ST_USER
         && state_reg != crc_pkg::ST_RESET && config_restart_n;
   end
   // chain enable low once own data done; one output serves both chains
   // a restart pulls the whole chain back, so the next device is disabled too
   assign chain_enable_out_n = !(config_restart_n && (state_reg == crc_pkg::ST_WAIT_DONE ||
      state_reg == crc_pkg::ST_INIT || state_reg == crc_pkg::ST_USER));
   assign user_mode = (state_reg == crc_pkg::ST_USER) && config_restart_n;
   assign io_tristate = !user_mode;
   assign io_weak_pullup = !user_mode && config_restart_n;

   // =========================================
   // checks
   property p_restart_drive;
      @(posedge clk) disable iff (rst)
      !config_restart_n |-> config_status_n_oe && config_complete_oe && io_tristate;
   endproperty
   a_restart_drive: assert property (p_restart_drive) else $error("restart drive");

   property p_config_start;
      @(posedge clk) disable iff (rst)
      state_reg == crc_pkg::ST_RESET && config_restart_n && config_status_n_in
         && !chip_enable_in_n |=> state_reg == crc_pkg::ST_CONFIG;
   endproperty
   a_config_start: assert property (p_config_start) else $error("no config start");

   property p_error_hold;
      @(posedge clk) disable iff (rst)
      state_reg == crc_pkg::ST_CONFIG && cfg_error && config_restart_n
         |=> config_status_n_oe && config_complete_oe;
   endproperty
   a_error_hold: assert property (p_error_hold) else $error("error not flagged");

   property p_retry_bound;
      @(posedge clk) disable iff (rst)
      retry_cnt_reg <= 14'(RETRY_COUNT);
   endproperty
   a_retry_bound: assert property (p_retry_bound) else $error("retry overrun");

   property p_init_count;
      @(posedge clk) disable iff (rst)
      state_reg == crc_pkg::ST_INIT && !init_tick && config_restart_n
         |=> $stable(init_cnt_reg);
   endproperty
   a_init_count: assert property (p_init_count) else $error("init moved without tick");

   property p_user_entry;
      @(posedge clk) disable iff (rst)
      $rose(user_mode) |-> $past(init_cnt_reg) == crc_pkg::INIT_CYCLES - 12'h001;
   endproperty
   a_user_entry: assert property (p_user_entry) else $error("early user mode");

   property p_init_release;
      @(posedge clk) disable iff (rst)
      user_mode |-> !init_complete_oe && !io_tristate && !io_weak_pullup;
   endproperty
   a_init_release: assert property (p_init_release) else $error("user mode pins");

   property p_chain_en;
      @(posedge clk) disable iff (rst)
      !chain_enable_out_n |-> !config_complete_oe;
   endproperty
   a_chain_en: assert property (p_chain_en) else $error("complete still held");

   property p_counter_clear;
      @(posedge clk) disable iff (rst)
      !config_restart_n |=> init_cnt_reg == 12'h000;
   endproperty
   a_counter_clear: assert property (p_counter_clear) else $error("counter not cleared");

   property p_status_release;
      @(posedge clk) disable iff (rst)
      state_reg == crc_pkg::ST_RESET && config_restart_n |-> !config_status_n_oe;
   endproperty
   a_status_release: assert property (p_status_release) else $error("status held");

   property p_init_oe_restart;
      @(posedge clk) disable iff (rst)
      !config_restart_n |-> !init_complete_oe;
   endproperty
   a_init_oe_restart: assert property (p_init_oe_restart) else $error("init driven");

   property p_first_frame;
      @(posedge clk) disable iff (rst)
      state_reg == crc_pkg::ST_CONFIG && cfg_data_valid && first_frame_reg
         |=> init_en_reg == $past(cfg_data[0]);
   endproperty
   a_first_frame: assert property (p_first_frame) else $error("enable bit lost");

   property p_wait_release;
      @(posedge clk) disable iff (rst)
      state_reg == crc_pkg::ST_WAIT_DONE && config_restart_n |-> !config_complete_oe;
   endproperty
   a_wait_release: assert property (p_wait_release) else $error("complete held");

   property p_error_pins;
      @(posedge clk) disable iff (rst)
      state_reg == crc_pkg::ST_ERROR |-> config_status_n_oe && config_complete_oe;
   endproperty
   a_error_pins: assert property (p_error_pins) else $error("error pins");

   property p_retry_release;
      @(posedge clk) disable iff (rst)
      state_reg == crc_pkg::ST_ERROR && auto_restart_en && config_restart_n
         && retry_cnt_reg == 14'(RETRY_COUNT - 1) |=> !config_status_n_oe || !config_restart_n;
   endproperty
   a_retry_release: assert property (p_retry_release) else $error("no release");

   property p_internal_count;
      @(posedge clk) disable iff (rst)
      state_reg == crc_pkg::ST_INIT && !user_clock_en && config_restart_n && config_complete_in
         |=> init_cnt_reg == $past(init_cnt_reg) + 12'h001;
   endproperty
   a_internal_count: assert property (p_internal_count) else $error("no tick");

   property p_user_clock_hold;
      @(posedge clk) disable iff (rst)
      state_reg == crc_pkg::ST_INIT && user_clock_en && !usr_d1_reg && config_restart_n
         |=> $stable(init_cnt_reg);
   endproperty
   a_user_clock_hold: assert property (p_user_clock_hold) else $error("held clock");

   property p_low_byte;
      @(posedge clk) disable iff (rst)
      chain_data_valid |-> chain_low_data == $past(cfg_data[7:0]);
   endproperty
   a_low_byte: assert property (p_low_byte) else $error("low byte");

   property p_high_byte;
      @(posedge clk) disable iff (rst)
      chain_data_valid |->
         chain_high_data == ($past(word_wide_mode) ? $past(cfg_data[15:8]) : 8'h00);
   endproperty
   a_high_byte: assert property (p_high_byte) else $error("high byte");
endmodule // crc_config_restart_init_chain

// *** bench/crc_partner.sv ***
`timescale 1ns/1ns
module crc_partner (
   // board side
   input wire logic clk,
   input wire logic status_oe,
   input wire logic complete_oe,
   input wire logic peer_busy,
   input wire logic uclk_run,
   // resolved lines
   output logic status_wire,
   output logic complete_wire,
   output logic uclk
);
   // ==========================================
   // shared open-drain lines with pull-ups
   assign status_wire = !status_oe;
   // a slower chained peer keeps the line low until its data is in
   assign complete_wire = !(complete_oe || peer_busy);
   // ==========================================
   // user start-up clock, stands still unless the host runs it
   logic [1:0] div_reg = 2'h0;
   always_ff @(posedge clk) begin
      div_reg <= div_reg + 2'h1;
   end
   assign uclk = uclk_run && div_reg[1];
endmodule // crc_partner

// *** bench/tb.sv ***
`timescale 1ns/1ns
module tb;
   typedef struct packed {
      logic ucl_en;
      logic wide;
      logic [15:0] data;
      logic [15:0] chain;
   } crc_row_s;
   crc_row_s rows [3] = '{'{1'b0, 1'b0, 16'hA5C3, 16'h00C3},
      '{1'b0, 1'b1, 16'h5A3D, 16'h5A3D}, '{1'b1, 1'b1, 16'hF00F, 16'hF00F}};
   logic clk, rst, auto_en, ucl_en, wide, restart_n, ce_n, valid, last, err;
   logic flash_wait = 1'b0;
   logic s_out, c_out, i_out;
   logic peer_busy, uclk_run, status_oe, complete_oe, status_w, complete_w, uclk;
   logic chain_n, init_oe, user_mode, io_tri, io_pu, cdv;
   logic [15:0] data;
   logic [7:0] lo, hi;
   int num_errors = 0;
   int compares = 0;
   int n, lo_b, hi_b;
   crc_config_restart_init_chain #(.RETRY_COUNT(10)) dut (.clk(clk), .rst(rst),
      .auto_restart_en(auto_en), .user_clock_en(ucl_en), .word_wide_mode(wide),
      .config_restart_n(restart_n), .chip_enable_in_n(ce_n), .config_status_n_in(status_w),
      .config_status_n_out(s_out), .config_status_n_oe(status_oe),
      .config_complete_in(complete_w), .config_complete_out(c_out),
      .config_complete_oe(complete_oe), .chain_enable_out_n(chain_n),
      .init_complete_out(i_out), .init_complete_oe(init_oe), .user_startup_clock(uclk),
      .flash_wait(flash_wait), .cfg_data(data), .cfg_data_valid(valid),
      .cfg_data_last(last), .cfg_error(err), .chain_low_data(lo), .chain_high_data(hi),
      .chain_data_valid(cdv), .user_mode(user_mode), .io_tristate(io_tri),
      .io_weak_pullup(io_pu));
   crc_partner far (.clk(clk), .status_oe(status_oe), .complete_oe(complete_oe),
      .peer_busy(peer_busy), .uclk_run(uclk_run), .status_wire(status_w),
      .complete_wire(complete_w), .uclk(uclk));
   initial begin
      clk = 1'b0;
      forever #10 clk = !clk;
   end
   // noise on the flash wait pin must change nothing
   always @(posedge clk) flash_wait <= !flash_wait;
   task automatic complete_run();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic restart();
      @(posedge clk) restart_n <= 1'b0;
      repeat (25) @(posedge clk);
      @(negedge clk);
      chk("restart pins", 16'h7, 16'({status_oe, complete_oe, io_tri}));
      @(posedge clk) restart_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   task automatic send(input logic [15:0] w, input logic l, input logic e);
      @(posedge clk) begin
         data <= w;
         valid <= !e;
         last <= l;
         err <= e;
      end
      @(posedge clk) begin
         valid <= 1'b0;
         last <= 1'b0;
         err <= 1'b0;
      end
      @(negedge clk);
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      complete_run();
   end
   initial begin
      {rst, restart_n, peer_busy} = 3'h7;
      {auto_en, ucl_en, wide, ce_n, valid, last, err, uclk_run} = 8'h00;
      data = 16'h0000;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         @(posedge clk) begin
            {ucl_en, wide, auto_en} <= {rows[i].ucl_en, rows[i].wide, rows[i].ucl_en};
            uclk_run <= 1'b0;
            peer_busy <= 1'b1;
         end
         restart();
         send(rows[i].data, 1'b1, 1'b0);
         chk("chain data", rows[i].chain, {hi, lo});
         chk("chain valid", 16'h1, 16'(cdv));
         chk("done pins", 16'h1, 16'({chain_n, complete_oe, init_oe}));
         repeat (8) @(negedge clk);
         chk("peer wait", 16'h0, 16'(user_mode));
         @(posedge clk) peer_busy <= 1'b0;
         n = 0;
         repeat (rows[i].ucl_en ? 3300 : 40) begin
            @(negedge clk);
            n++;
         end
         chk("clock held", 16'h0, 16'(user_mode));
         @(posedge clk) uclk_run <= 1'b1;
         while (user_mode !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
         end
         lo_b = rows[i].ucl_en ? 16050 : 3191;
         hi_b = rows[i].ucl_en ? 16090 : 3197;
         chk("init cycles", 16'h1, 16'(n >= lo_b && n <= hi_b));
         chk("user pins", 16'h8, 16'({user_mode, init_oe, io_tri, io_pu}));
      end
      // error with retry: timeout then configuration resumes by itself
      @(posedge clk) auto_en <= 1'b1;
      restart();
      send(16'h0001, 1'b0, 1'b1);
      chk("error pins", 16'h3, 16'({status_oe, complete_oe}));
      n = 0;
      while (status_oe !== 1'b0 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk("retry time", 16'h1, 16'(n >= 5 && n <= 14));
      repeat (3) @(posedge clk);
      send(16'h0003, 1'b1, 1'b0);
      chk("retried", 16'h0, 16'(chain_n));
      // error without retry waits for the host
      @(posedge clk) auto_en <= 1'b0;
      restart();
      send(16'h0001, 1'b0, 1'b1);
      repeat (40) @(negedge clk);
      chk("held error", 16'h3, 16'({status_oe, complete_oe}));
      restart();
      send(16'h0005, 1'b1, 1'b0);
      chk("reconfigured", 16'h0, 16'(chain_n));
      // chip enable high keeps the device out of configuration
      @(posedge clk) ce_n <= 1'b1;
      restart();
      send(16'h0007, 1'b1, 1'b0);
      chk("disabled", 16'h2, 16'({chain_n, cdv}));
      // mid-run reset, then the device configures again by itself
      @(posedge clk) {rst, ce_n} <= 2'h2;
      @(negedge clk);
      chk("reset outs", 16'h6, 16'({chain_n, complete_oe, status_oe}));
      chk("reset modes", 16'h1, 16'({init_oe, user_mode, io_tri}));
      chk("drive levels", 16'h0, 16'({s_out, c_out, i_out}));
      @(posedge clk) rst <= 1'b0;
      send(16'h0009, 1'b1, 1'b0);
      chk("after reset", 16'h0, 16'(chain_n));
      complete_run();
   end
endmodule // tb
